// file: sleep_scan_defs.svh
// Constants of the sleep, scan and timeout parameter block
`ifndef SLEEP_SCAN_DEFS_SVH
`define SLEEP_SCAN_DEFS_SVH

// ----------------------------------------
// Reset and limit values
// ----------------------------------------
`define SCAN_EXP_RST 8'h04
`define SCAN_EXP_MAX 8'h0F
`define CHAN_MASK_RST 16'h1FFE
`define CHAN_MASK_STD 16'hFFFF
`define CHAN_MASK_HP 16'h1FFE
`define SLEEP_MODE_RST 8'h00
`define SLEEP_MODE_MAX 8'h06
`define SLEEP_OPT_RST 8'h00
`define SLEEP_OPT_MAX 8'h04
`define SLEEP_PER_RST 16'h0064
`define SLEEP_PER_MAX 16'h68B0
`define INACT_RST 16'h1388
`define INACT_MIN 16'h0001
`define OUT_TMO_RST 8'hFF
`define VERBOSE_VER 8'h28

// ----------------------------------------
// Field positions and mode codes
// ----------------------------------------
`define OPT_NO_POLL 0
`define OPT_NO_SAMPLE 1
`define MODE_OFF 8'h00
`define MODE_PIN_HIB 8'h01
`define MODE_PIN_DOZE 8'h02
`define MODE_CYC 8'h04
`define MODE_CYC_PIN 8'h05
`define MODE_CYC_COORD 8'h06

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 5
`define MS_NS 1000000
`define SCAN_BASE_NS 15360000
`define SLEEP_UNIT_MS 10
`define OUT_UNIT_MS 100
`define HOLD_MS_PER_UNIT 25
`define COMMIT_CYCLES 16

`endif

// file: sleep_scan_pkg.sv
// Types of the sleep, scan and timeout parameter block
`default_nettype none
package sleep_scan_pkg;
   typedef enum logic [2:0] {op_read, op_write, op_commit, op_restore, op_reload} op_t;
   typedef enum logic [3:0] {par_scan_exponent, par_channel_mask, par_serial_upper,
      par_serial_lower, par_sleep_mode, par_sleep_opt, par_sleep_period,
      par_inactivity, par_out_timeout, par_verbose_ver, par_fw_version} param_t;
   typedef enum logic [1:0] {st_awake, st_sleep, st_check} sleep_state_t;
endpackage
`default_nettype wire

// file: sleep_scan_params.sv
// Sleep, scan and output timeout parameter logic of the radio module
`include "sleep_scan_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sleep_scan_params #(
   parameter int MS_CYCLES = `MS_NS / `CLK_PERIOD_NS,
   parameter int SCAN_BASE_CYCLES = `SCAN_BASE_NS / `CLK_PERIOD_NS,
   parameter bit HIGH_POWER = 1'b0,
   parameter logic [63:0] SERIAL_NUMBER = 64'h0123_4567_89AB_CDEF, // arbitrary value
   parameter logic [15:0] FW_VERSION = 16'h10C0, // arbitrary value
   parameter logic [7:0] OUT_DEFAULT = 8'h00
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic cmd_valid_i,
   input wire sleep_scan_pkg::op_t cmd_op_i,
   input wire sleep_scan_pkg::param_t cmd_param_i,
   input wire logic [2:0] cmd_index_i,
   input wire logic [31:0] cmd_data_i,
   output logic rsp_valid_o,
   output logic rsp_ok_o,
   output logic [31:0] rsp_data_o,
   output logic host_busy_o,
   input wire logic coordinator_i,
   input wire logic network_id_reselect_i,
   input wire logic channel_reselect_i,
   input wire logic scan_start_i,
   output logic scan_busy_o,
   output logic energy_scan_o,
   output logic [19:0] scan_units_o,
   input wire logic sleep_pin_i,
   input wire logic data_pending_i,
   input wire logic sampling_en_i,
   output logic asleep_o,
   output logic poll_o,
   output logic sample_o,
   input wire logic host_rx_valid_i,
   input wire logic [7:0] host_rx_data_i,
   input wire logic radio_rx_valid_i,
   input wire logic [7:0] radio_rx_data_i,
   output logic radio_tx_valid_o,
   output logic [7:0] radio_tx_data_o,
   output logic host_tx_valid_o,
   output logic [7:0] host_tx_data_o,
   input wire logic indirect_store_i,
   input wire logic indirect_taken_i,
   output logic indirect_pending_o,
   output logic indirect_discard_o,
   output logic direct_send_o,
   input wire logic io_packet_i,
   input wire logic [7:0] io_levels_i,
   output logic [7:0] io_out_o
);
   import sleep_scan_pkg::*;

   // ----------------------------------------
   // Working and stored settings
   // ----------------------------------------
   logic [7:0] scan_exponent;
   logic [15:0] channel_mask;
   logic [7:0] sleep_mode_select;
   logic [7:0] sleep_option_bits;
   logic [15:0] cyclic_sleep_period;
   logic [15:0] inactivity_before_sleep;
   logic [7:0] output_line_timeouts [8];
   logic [7:0] nv_scan_exponent;
   logic [15:0] nv_channel_mask;
   logic [7:0] nv_sleep_mode;
   logic [7:0] nv_sleep_opt;
   logic [15:0] nv_sleep_period;
   logic [15:0] nv_inactivity;
   logic [7:0] nv_timeouts [8];
   logic load_pending;
   logic [4:0] commit_cnt;
   logic sleep_pin_meta;
   logic sleep_pin_s;

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   wire cmd_take = cmd_valid_i & ~host_busy_o & ~load_pending;
   wire is_wr = cmd_take & (cmd_op_i == op_write);
   wire is_rd = cmd_take & (cmd_op_i == op_read);
   wire is_commit = cmd_take & (cmd_op_i == op_commit);
   wire is_restore = cmd_take & (cmd_op_i == op_restore);
   wire is_reload = cmd_take & (cmd_op_i == op_reload);
   wire [15:0] chan_allowed = HIGH_POWER ? `CHAN_MASK_HP : `CHAN_MASK_STD;
   wire ok_sd = cmd_data_i <= {24'h0, `SCAN_EXP_MAX};
   wire ok_sc = (cmd_data_i[15:0] != 16'h0000) && (cmd_data_i[31:16] == 16'h0000)
      && ((cmd_data_i[15:0] & ~chan_allowed) == 16'h0000);
   wire ok_sm = (cmd_data_i <= {24'h0, `SLEEP_MODE_MAX}) && (cmd_data_i != 32'h3);
   wire ok_so = cmd_data_i <= {24'h0, `SLEEP_OPT_MAX};
   wire ok_sp = cmd_data_i <= {16'h0, `SLEEP_PER_MAX};
   wire ok_st = (cmd_data_i >= {16'h0, `INACT_MIN}) && (cmd_data_i[31:16] == 16'h0000);
   wire ok_tn = cmd_data_i[31:8] == 24'h0;
   wire wr_ok = (cmd_param_i == par_scan_exponent) ? ok_sd :
      (cmd_param_i == par_channel_mask) ? ok_sc :
      (cmd_param_i == par_sleep_mode) ? ok_sm :
      (cmd_param_i == par_sleep_opt) ? ok_so :
      (cmd_param_i == par_sleep_period) ? ok_sp :
      (cmd_param_i == par_inactivity) ? ok_st :
      (cmd_param_i == par_out_timeout) ? ok_tn : 1'b0;
   wire wr_do = is_wr & wr_ok;
   logic [31:0] rd_data;
   always_comb
   begin
      case (cmd_param_i)
         par_scan_exponent: rd_data = {24'h0, scan_exponent};
         par_channel_mask: rd_data = {16'h0, channel_mask};
         par_serial_upper: rd_data = SERIAL_NUMBER[63:32];
         par_serial_lower: rd_data = SERIAL_NUMBER[31:0];
         par_sleep_mode: rd_data = {24'h0, sleep_mode_select};
         par_sleep_opt: rd_data = {24'h0, sleep_option_bits};
         par_sleep_period: rd_data = {16'h0, cyclic_sleep_period};
         par_inactivity: rd_data = {16'h0, inactivity_before_sleep};
         par_out_timeout: rd_data = {24'h0, output_line_timeouts[cmd_index_i]};
         par_verbose_ver: rd_data = {24'h0, `VERBOSE_VER};
         par_fw_version: rd_data = {16'h0, FW_VERSION};
         default: rd_data = 32'h0;
      endcase
   end

   // ----------------------------------------
   // Settings storage
   // ----------------------------------------
   wire load_work = load_pending | is_reload;
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         scan_exponent <= `SCAN_EXP_RST;
         channel_mask <= `CHAN_MASK_RST;
         sleep_mode_select <= `SLEEP_MODE_RST;
         sleep_option_bits <= `SLEEP_OPT_RST;
         cyclic_sleep_period <= `SLEEP_PER_RST;
         inactivity_before_sleep <= `INACT_RST;
         nv_scan_exponent <= `SCAN_EXP_RST;
         nv_channel_mask <= `CHAN_MASK_RST;
         nv_sleep_mode <= `SLEEP_MODE_RST;
         nv_sleep_opt <= `SLEEP_OPT_RST;
         nv_sleep_period <= `SLEEP_PER_RST;
         nv_inactivity <= `INACT_RST;
         load_pending <= 1'b1;
      end
      else
      begin
         load_pending <= 1'b0;
         if (load_work)
         begin
            scan_exponent <= nv_scan_exponent;
            channel_mask <= nv_channel_mask;
            sleep_mode_select <= nv_sleep_mode;
            sleep_option_bits <= nv_sleep_opt;
            cyclic_sleep_period <= nv_sleep_period;
            inactivity_before_sleep <= nv_inactivity;
         end
         else if (is_restore)
         begin
            scan_exponent <= `SCAN_EXP_RST;
            channel_mask <= `CHAN_MASK_RST;
            sleep_mode_select <= `SLEEP_MODE_RST;
            sleep_option_bits <= `SLEEP_OPT_RST;
            cyclic_sleep_period <= `SLEEP_PER_RST;
            inactivity_before_sleep <= `INACT_RST;
         end
         else if (wr_do)
         begin
            case (cmd_param_i)
               par_scan_exponent: scan_exponent <= cmd_data_i[7:0];
               par_channel_mask: channel_mask <= cmd_data_i[15:0];
               par_sleep_mode: sleep_mode_select <= cmd_data_i[7:0];
               par_sleep_opt: sleep_option_bits <= cmd_data_i[7:0];
               par_sleep_period: cyclic_sleep_period <= cmd_data_i[15:0];
               par_inactivity: inactivity_before_sleep <= cmd_data_i[15:0];
               default: ;
            endcase
         end
         if (is_commit)
         begin
            nv_scan_exponent <= scan_exponent;
            nv_channel_mask <= channel_mask;
            nv_sleep_mode <= sleep_mode_select;
            nv_sleep_opt <= sleep_option_bits;
            nv_sleep_period <= cyclic_sleep_period;
            nv_inactivity <= inactivity_before_sleep;
         end
      end
   end

   // ----------------------------------------
   // Command answers and commit busy
   // ----------------------------------------
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rsp_valid_o <= 1'b0;
         rsp_ok_o <= 1'b0;
         rsp_data_o <= 32'h0;
         host_busy_o <= 1'b0;
         commit_cnt <= 5'd0;
      end
      else
      begin
         rsp_valid_o <= (cmd_take & ~is_commit) | (host_busy_o & (commit_cnt == 5'd1));
         rsp_ok_o <= is_wr ? wr_ok : 1'b1;
         rsp_data_o <= is_rd ? rd_data : 32'h0;
         if (is_commit)
         begin
            host_busy_o <= 1'b1;
            commit_cnt <= 5'(`COMMIT_CYCLES);
         end
         else if (host_busy_o)
         begin
            commit_cnt <= commit_cnt - 5'd1;
            host_busy_o <= commit_cnt != 5'd1;
         end
      end
   end

   // ----------------------------------------
   // Millisecond tick
   // ----------------------------------------
   logic [31:0] pre_cnt;
   logic ms_tick;
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pre_cnt <= 32'h0;
         ms_tick <= 1'b0;
      end
      else
      begin
         ms_tick <= pre_cnt == 32'(MS_CYCLES - 1);
         pre_cnt <= (pre_cnt == 32'(MS_CYCLES - 1)) ? 32'h0 : pre_cnt + 32'h1;
      end
   end

   // ----------------------------------------
   // Scan timing
   // ----------------------------------------
   function automatic logic [4:0] count_ones(input logic [15:0] v);
      logic [4:0] n;
      n = 5'd0;
      for (int i = 0; i < 16; i++)
         n = n + {4'h0, v[i]};
      return n;
   endfunction
   wire [15:0] chan_used = channel_mask & chan_allowed;
   wire [19:0] next_scan_units = 20'(count_ones(chan_used)) << scan_exponent[3:0];
   logic [31:0] base_cnt;
   logic [19:0] unit_cnt;
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         scan_busy_o <= 1'b0;
         energy_scan_o <= 1'b0;
         scan_units_o <= 20'h0;
         base_cnt <= 32'h0;
         unit_cnt <= 20'h0;
      end
      else
      begin
         scan_units_o <= next_scan_units;
         if (scan_start_i && !scan_busy_o)
         begin
            scan_busy_o <= 1'b1;
            energy_scan_o <= coordinator_i & channel_reselect_i & ~network_id_reselect_i;
            base_cnt <= 32'h0;
            unit_cnt <= next_scan_units;
         end
         else if (scan_busy_o)
         begin
            base_cnt <= (base_cnt == 32'(SCAN_BASE_CYCLES - 1)) ? 32'h0 : base_cnt + 32'h1;
            if (base_cnt == 32'(SCAN_BASE_CYCLES - 1))
            begin
               unit_cnt <= unit_cnt - 20'h1;
               scan_busy_o <= unit_cnt != 20'h1;
            end
         end
      end
   end

   // ----------------------------------------
   // Sleep sequencing
   // ----------------------------------------
   sleep_state_t state;
   logic [19:0] slp_ms;
   wire mode_cyc = (sleep_mode_select == `MODE_CYC) || (sleep_mode_select == `MODE_CYC_PIN);
   wire mode_pin = (sleep_mode_select == `MODE_PIN_HIB) || (sleep_mode_select == `MODE_PIN_DOZE);
   wire activity = host_rx_valid_i | radio_rx_valid_i;
   wire [19:0] sleep_ms = 20'(cyclic_sleep_period) * 20'(`SLEEP_UNIT_MS);
   wire inact_done = slp_ms >= {4'h0, inactivity_before_sleep};
   wire sleep_done = slp_ms >= sleep_ms;
   wire pin_wake = (sleep_mode_select == `MODE_CYC_PIN) && !sleep_pin_s;
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sleep_pin_meta <= 1'b0;
         sleep_pin_s <= 1'b0;
      end
      else
      begin
         sleep_pin_meta <= sleep_pin_i;
         sleep_pin_s <= sleep_pin_meta;
      end
   end
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state <= st_awake;
         slp_ms <= 20'h0;
         asleep_o <= 1'b0;
         poll_o <= 1'b0;
         sample_o <= 1'b0;
      end
      else
      begin
         poll_o <= 1'b0;
         sample_o <= 1'b0;
         case (state)
            st_awake:
            begin
               asleep_o <= 1'b0;
               if (mode_pin && sleep_pin_s)
               begin
                  state <= st_sleep;
                  asleep_o <= 1'b1;
               end
               else if (!mode_cyc || activity)
                  slp_ms <= 20'h0;
               else if (inact_done)
               begin
                  state <= st_sleep;
                  asleep_o <= 1'b1;
                  slp_ms <= 20'h0;
               end
               else if (ms_tick)
                  slp_ms <= slp_ms + 20'h1;
            end
            st_sleep:
            begin
               if (mode_pin)
               begin
                  if (!sleep_pin_s)
                     state <= st_awake;
               end
               else if (!mode_cyc)
                  state <= st_awake;
               else if (sleep_done || pin_wake)
               begin
                  state <= st_check;
                  asleep_o <= 1'b0;
                  slp_ms <= 20'h0;
                  poll_o <= ~sleep_option_bits[`OPT_NO_POLL];
                  sample_o <= sampling_en_i & ~sleep_option_bits[`OPT_NO_SAMPLE];
               end
               else if (ms_tick)
                  slp_ms <= slp_ms + 20'h1;
            end
            st_check:
            begin
               if (data_pending_i || activity || pin_wake)
                  state <= st_awake;
               else
               begin
                  state <= st_sleep;
                  asleep_o <= 1'b1;
               end
            end
            default: state <= st_awake;
         endcase
      end
   end

   // ----------------------------------------
   // Indirect message hold
   // ----------------------------------------
   logic [20:0] hold_ms;
   wire period_used = (sleep_mode_select >= `MODE_CYC) || coordinator_i;
   wire hold_on = coordinator_i && period_used && (cyclic_sleep_period != 16'h0000);
   wire [20:0] hold_lim = 21'(cyclic_sleep_period) * 21'(`HOLD_MS_PER_UNIT);
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         indirect_pending_o <= 1'b0;
         indirect_discard_o <= 1'b0;
         direct_send_o <= 1'b1;
         hold_ms <= 21'h0;
      end
      else
      begin
         direct_send_o <= ~hold_on;
         indirect_discard_o <= 1'b0;
         if (indirect_store_i && hold_on)
         begin
            indirect_pending_o <= 1'b1;
            hold_ms <= 21'h0;
         end
         else if (indirect_pending_o)
         begin
            if (indirect_taken_i || !hold_on)
               indirect_pending_o <= 1'b0;
            else if (hold_ms >= hold_lim)
            begin
               indirect_pending_o <= 1'b0;
               indirect_discard_o <= 1'b1;
            end
            else if (ms_tick)
               hold_ms <= hold_ms + 21'h1;
         end
      end
   end

   // ----------------------------------------
   // Transparent data path
   // ----------------------------------------
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         radio_tx_valid_o <= 1'b0;
         radio_tx_data_o <= 8'h00;
         host_tx_valid_o <= 1'b0;
         host_tx_data_o <= 8'h00;
      end
      else
      begin
         radio_tx_valid_o <= host_rx_valid_i & ~host_busy_o;
         radio_tx_data_o <= host_rx_data_i;
         host_tx_valid_o <= radio_rx_valid_i;
         host_tx_data_o <= radio_rx_data_i;
      end
   end

   // ----------------------------------------
   // Passed output lines with timeouts
   // ----------------------------------------
   for (genvar g = 0; g < 8; g++)
   begin : g_line
      logic [14:0] out_ms;
      wire [14:0] out_lim = 15'(output_line_timeouts[g]) * 15'(`OUT_UNIT_MS);
      wire sel = wr_do && (cmd_param_i == par_out_timeout) && (cmd_index_i == 3'(g));
      always_ff @(posedge core_clk_i or negedge nrst_i)
      begin
         if (!nrst_i)
         begin
            output_line_timeouts[g] <= `OUT_TMO_RST;
            nv_timeouts[g] <= `OUT_TMO_RST;
            io_out_o[g] <= OUT_DEFAULT[g];
            out_ms <= 15'h0;
         end
         else
         begin
            if (load_work)
               output_line_timeouts[g] <= nv_timeouts[g];
            else if (is_restore)
               output_line_timeouts[g] <= `OUT_TMO_RST;
            else if (sel)
               output_line_timeouts[g] <= cmd_data_i[7:0];
            if (is_commit)
               nv_timeouts[g] <= output_line_timeouts[g];
            if (io_packet_i)
            begin
               io_out_o[g] <= io_levels_i[g];
               out_ms <= 15'h0;
            end
            else if (io_out_o[g] != OUT_DEFAULT[g] && output_line_timeouts[g] != 8'h00)
            begin
               if (out_ms >= out_lim)
                  io_out_o[g] <= OUT_DEFAULT[g];
               else if (ms_tick)
                  out_ms <= out_ms + 15'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: sleep_scan_params_asserts.sv
// Property checker for the sleep, scan and timeout parameter block
`timescale 1ns/1ps
`default_nettype none
module sleep_scan_params_asserts
   import sleep_scan_pkg::*;
#(
   parameter int SCAN_BASE_CYCLES = 3,
   parameter logic [15:0] FW_VERSION = 16'h10C0
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic cmd_valid_i,
   input wire sleep_scan_pkg::op_t cmd_op_i,
   input wire sleep_scan_pkg::param_t cmd_param_i,
   input wire logic rsp_valid_o,
   input wire logic rsp_ok_o,
   input wire logic [31:0] rsp_data_o,
   input wire logic host_busy_o,
   input wire logic coordinator_i,
   input wire logic network_id_reselect_i,
   input wire logic channel_reselect_i,
   input wire logic scan_start_i,
   input wire logic scan_busy_o,
   input wire logic energy_scan_o,
   input wire logic [19:0] scan_units_o,
   input wire logic host_rx_valid_i,
   input wire logic [7:0] host_rx_data_i,
   input wire logic radio_rx_valid_i,
   input wire logic [7:0] radio_rx_data_i,
   input wire logic radio_tx_valid_o,
   input wire logic [7:0] radio_tx_data_o,
   input wire logic host_tx_valid_o,
   input wire logic [7:0] host_tx_data_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   logic live;
   logic [31:0] busy_cnt;
   logic [4:0] commit_len;
   wire take = cmd_valid_i && !host_busy_o && live;
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         live <= 1'b0;
         busy_cnt <= '0;
         commit_len <= 5'd0;
      end
      else
      begin
         live <= 1'b1;
         busy_cnt <= scan_busy_o ? busy_cnt + 32'd1 : 32'd0;
         commit_len <= host_busy_o ? commit_len + 5'd1 : 5'd0;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_scan_length: assert property ($fell(scan_busy_o) |->
      busy_cnt == scan_units_o * SCAN_BASE_CYCLES) else $error("scan length wrong");
   a_scan_starts: assert property (scan_start_i && !scan_busy_o |=> scan_busy_o)
      else $error("scan did not start");
   a_energy_kind: assert property (scan_start_i && !scan_busy_o |=> energy_scan_o ==
      $past(coordinator_i && channel_reselect_i && !network_id_reselect_i)) else $error("scan kind");
   a_serial_refuse: assert property (take && cmd_op_i == op_write && (cmd_param_i ==
      par_serial_upper || cmd_param_i == par_serial_lower) |=> rsp_valid_o && !rsp_ok_o)
      else $error("serial write not refused");
   a_version_read: assert property (take && cmd_op_i == op_read &&
      cmd_param_i == par_fw_version |=> rsp_ok_o && rsp_data_o == {16'h0000, FW_VERSION})
      else $error("version read wrong");
   a_commit_wait: assert property (take && cmd_op_i == op_commit |=> host_busy_o ##16
      (rsp_valid_o && rsp_ok_o && !host_busy_o && commit_len == 5'd16)) else $error("bad commit");
   a_host_to_radio: assert property (host_rx_valid_i && !host_busy_o |=>
      radio_tx_valid_o && radio_tx_data_o == $past(host_rx_data_i)) else $error("host byte lost");
   a_radio_to_host: assert property (radio_rx_valid_i |=>
      host_tx_valid_o && host_tx_data_o == $past(radio_rx_data_i)) else $error("radio byte lost");
   c_scan: cover property ($fell(scan_busy_o));
   c_commit: cover property (take && cmd_op_i == op_commit);
   c_refuse: cover property (rsp_valid_o && !rsp_ok_o);
endmodule
bind sleep_scan_params sleep_scan_params_asserts #(.SCAN_BASE_CYCLES(SCAN_BASE_CYCLES),
   .FW_VERSION(FW_VERSION)) sleep_scan_params_asserts_inst (.*);
`default_nettype wire

// file: host_model.sv
// Host controller model issuing commands and waiting for each answer
`timescale 1ns/1ps
`default_nettype none
module host_model
   import sleep_scan_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rsp_valid_i,
   input wire logic rsp_ok_i,
   input wire logic [31:0] rsp_data_i,
   output logic cmd_valid_o,
   output sleep_scan_pkg::op_t cmd_op_o,
   output sleep_scan_pkg::param_t cmd_param_o,
   output logic [2:0] cmd_index_o,
   output logic [31:0] cmd_data_o
);
   initial cmd_valid_o = 1'b0;
   task automatic cmd(input op_t op, input param_t p, input logic [2:0] i,
      input logic [31:0] d, output logic ok, output logic [31:0] q);
      int n = 0;
      @(negedge core_clk_i);
      cmd_valid_o = 1'b1;
      cmd_op_o = op;
      cmd_param_o = p;
      cmd_index_o = i;
      cmd_data_o = d;
      @(negedge core_clk_i);
      cmd_valid_o = 1'b0;
      cmd_data_o = ~d;
      // Silent until the answer arrives, for at most 40 cycles
      while (!rsp_valid_i && n < 40)
      begin
         @(negedge core_clk_i);
         n++;
      end
      ok = rsp_valid_i ? rsp_ok_i : 1'bx;
      q = rsp_data_i;
   endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench of the sleep, scan and timeout parameter block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import sleep_scan_pkg::*;
   logic core_clk_i, nrst_i, cmd_valid_i, rsp_valid_o, rsp_ok_o, host_busy_o, coordinator_i;
   logic network_id_reselect_i, channel_reselect_i, scan_start_i, scan_busy_o, energy_scan_o;
   logic sleep_pin_i, data_pending_i, sampling_en_i, asleep_o, poll_o, sample_o, direct_send_o;
   logic host_rx_valid_i, radio_rx_valid_i, radio_tx_valid_o, host_tx_valid_o, ok, io_packet_i;
   logic indirect_store_i, indirect_taken_i, indirect_pending_o, indirect_discard_o;
   logic [7:0] host_rx_data_i, radio_rx_data_i, radio_tx_data_o, host_tx_data_o;
   logic [7:0] io_levels_i, io_out_o;
   logic [19:0] scan_units_o;
   logic [2:0] cmd_index_i;
   logic [31:0] cmd_data_i, rsp_data_o, q;
   op_t cmd_op_i;
   param_t cmd_param_i;
   int n_mismatch, checks, n;
   sleep_scan_params #(.MS_CYCLES(4), .SCAN_BASE_CYCLES(3)) sleep_scan_params_inst (.*);
   host_model host_model_inst (.core_clk_i(core_clk_i), .rsp_valid_i(rsp_valid_o),
      .rsp_ok_i(rsp_ok_o), .rsp_data_i(rsp_data_o), .cmd_valid_o(cmd_valid_i),
      .cmd_op_o(cmd_op_i), .cmd_param_o(cmd_param_i), .cmd_index_o(cmd_index_i),
      .cmd_data_o(cmd_data_i));
   always #2.5 core_clk_i = ~core_clk_i;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input param_t p, input logic [2:0] i, input logic [31:0] e);
      host_model_inst.cmd(op_read, p, i, 32'h0000_0000, ok, q);
      chk({31'h0, ok}, 32'h0000_0001);
      chk(q, e);
   endtask
   task automatic wr(input param_t p, input logic [2:0] i, input logic [31:0] d, input logic e);
      host_model_inst.cmd(op_write, p, i, d, ok, q);
      chk({31'h0, ok}, {31'h0, e});
   endtask
   task automatic wait_hi(ref logic s);
      n = 0;
      while (s !== 1'b1 && n < 300)
      begin
         @(negedge core_clk_i);
         n++;
      end
   endtask
   task automatic tally_and_finish;
      if (n_mismatch == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (30000) @(posedge core_clk_i);
      n_mismatch++;
      tally_and_finish;
   end
   initial
   begin
      {core_clk_i, nrst_i, coordinator_i, network_id_reselect_i, channel_reselect_i} = '0;
      {scan_start_i, sleep_pin_i, data_pending_i, sampling_en_i, host_rx_valid_i} = 5'h02;
      {radio_rx_valid_i, indirect_store_i, indirect_taken_i, io_packet_i} = '0;
      {host_rx_data_i, radio_rx_data_i, io_levels_i} = '0;
      repeat (16) @(posedge core_clk_i);
      @(negedge core_clk_i) nrst_i = 1'b1;
      rd(par_scan_exponent, 0, 32'h0000_0004);
      rd(par_sleep_mode, 0, 32'h0000_0000);
      rd(par_out_timeout, 3, 32'h0000_00FF);
      rd(par_serial_upper, 0, 32'h0123_4567);
      rd(par_serial_lower, 0, 32'h89AB_CDEF);
      rd(par_fw_version, 0, 32'h0000_10C0);
      wr(par_serial_lower, 0, 32'h0000_0001, 0);
      wr(par_scan_exponent, 0, 32'h0000_0010, 0);
      wr(par_scan_exponent, 0, 32'h0000_000F, 1);
      for (int m = 0; m < 8; m++)
         wr(par_sleep_mode, 0, m, m != 3 && m < 7);
      wr(par_channel_mask, 0, 32'h0000_FFFF, 1);
      wr(par_channel_mask, 0, 32'h0000_0003, 1);
      wr(par_scan_exponent, 0, 32'h0000_0001, 1);
      {coordinator_i, channel_reselect_i, scan_start_i} = 3'b111;
      @(negedge core_clk_i) scan_start_i = 1'b0;
      chk({12'h000, scan_units_o}, 32'h0000_0004);
      chk({31'h0, energy_scan_o}, 32'h0000_0001);
      repeat (20) @(negedge core_clk_i);
      chk({31'h0, scan_busy_o}, 32'h0000_0000);
      host_model_inst.cmd(op_commit, par_scan_exponent, 0, 0, ok, q);
      chk({31'h0, ok}, 32'h0000_0001);
      wr(par_scan_exponent, 0, 32'h0000_0007, 1);
      host_model_inst.cmd(op_reload, par_scan_exponent, 0, 0, ok, q);
      rd(par_scan_exponent, 0, 32'h0000_0001);
      host_model_inst.cmd(op_restore, par_scan_exponent, 0, 0, ok, q);
      rd(par_scan_exponent, 0, 32'h0000_0004);
      {host_rx_valid_i, radio_rx_valid_i, host_rx_data_i, radio_rx_data_i} = 18'h3_A55A;
      @(negedge core_clk_i) {host_rx_valid_i, radio_rx_valid_i} = 2'b00;
      chk({radio_tx_valid_o, host_tx_valid_o, radio_tx_data_o, host_tx_data_o}, 18'h3_A55A);
      wr(par_out_timeout, 0, 32'h0000_0001, 1);
      wr(par_out_timeout, 1, 32'h0000_0000, 1);
      {io_packet_i, io_levels_i} = 9'h103;
      @(negedge core_clk_i) io_packet_i = 1'b0;
      repeat (380) @(negedge core_clk_i);
      chk(io_out_o, 8'h03);
      repeat (40) @(negedge core_clk_i);
      chk(io_out_o, 8'h02);
      wr(par_sleep_period, 0, 32'h0000_0001, 1);
      indirect_store_i = 1'b1;
      @(negedge core_clk_i) indirect_store_i = 1'b0;
      chk({30'h0, indirect_pending_o, direct_send_o}, 32'h0000_0002);
      wait_hi(indirect_discard_o);
      chk(n >= 95 && n <= 105, 32'h0000_0001);
      wr(par_inactivity, 0, 32'h0000_0001, 1);
      wr(par_sleep_mode, 0, 32'h0000_0004, 1);
      wait_hi(asleep_o);
      chk(n < 12, 32'h0000_0001);
      wait_hi(poll_o);
      chk({n >= 36 && n <= 44, sample_o}, 32'h0000_0003);
      wr(par_sleep_mode, 0, 32'h0000_0000, 1);
      wr(par_sleep_period, 0, 32'h0000_0000, 1);
      repeat (20) @(negedge core_clk_i);
      chk({30'h0, asleep_o, direct_send_o}, 32'h0000_0001);
      tally_and_finish;
   end
endmodule
`default_nettype wire
